// ### core/ppo_pkg.sv
// Package for the profile position option block: object indices, field layout,
// preset values and selector codes.
// Assumes a 16-bit object index bus driven by the fieldbus object dictionary logic.
package ppo_pkg;
   // Object indices
   localparam logic [15:0] IDX_MAX_ACCEL = 16'h60C5;
   localparam logic [15:0] IDX_MAX_DECEL = 16'h60C6;
   localparam logic [15:0] IDX_POS_OPT = 16'h60F2;
   localparam logic [15:0] IDX_TRACK_ERR = 16'h60F4;
   // Preset values
   localparam logic [31:0] RST_MAX_ACCEL = 32'h0000_1388;
   localparam logic [31:0] RST_MAX_DECEL = 32'h0000_1388;
   localparam logic [15:0] RST_POS_OPT = 16'h0001;
   localparam logic [31:0] RST_TRACK_ERR = 32'h0000_0000;
   // Option word field positions
   localparam int REL_LSB = 0;
   localparam int HSK_LSB = 4;
   localparam int ROT_LSB = 6;
   localparam int INTERP_LSB = 8;
   localparam int TOP_FLAG_POS = 15;
   // Controlword and statusword bit positions
   localparam int CW_NEW_SETPOINT = 5;
   localparam int CW_RELATIVE = 6;
   localparam int SW_SETPOINT_ACK = 12;
   // Two-bit selector codes
   typedef enum logic [1:0] {
      SEL_C0 = 2'b00,
      SEL_C1 = 2'b01,
      SEL_C2 = 2'b10,
      SEL_C3 = 2'b11
   } ppo_sel_t;
endpackage : ppo_pkg

// ### core/ppo_target_calc.sv
// Target position calculator for one new setpoint.
// Assumes positions in user units and a range min < max; all inputs synchronous.
`timescale 1ns/1ns
`default_nettype none
module ppo_target_calc (
   input wire logic [1:0] rel_sel_i,
   input wire logic [1:0] rot_sel_i,
   input wire logic relative_i,
   input wire logic has_prev_i,
   input wire logic signed [31:0] setpoint_i,
   input wire logic signed [31:0] prev_target_i,
   input wire logic signed [31:0] ramp_pos_i,
   input wire logic signed [31:0] actual_pos_i,
   input wire logic signed [31:0] range_min_i,
   input wire logic signed [31:0] range_max_i,
   output logic signed [31:0] target_o,
   output logic dir_neg_o
);
   logic signed [31:0] base;
   logic signed [32:0] sum;
   logic signed [32:0] span;
   logic signed [32:0] diff;
   logic signed [32:0] wrapped;

   // Relative base selection, reserved code acts as code 00
   always_comb begin
      base = '0;
      if (relative_i) begin
         unique case (ppo_pkg::ppo_sel_t'(rel_sel_i))
            ppo_pkg::SEL_C1: base = ramp_pos_i;
            ppo_pkg::SEL_C2: base = actual_pos_i;
            ppo_pkg::SEL_C0, ppo_pkg::SEL_C3: base = has_prev_i ? prev_target_i : '0;
         endcase
      end
   end

   // Sum with wrap to the opposite range limit
   always_comb begin
      sum = 33'(base) + 33'(setpoint_i);
      span = 33'(range_max_i) - 33'(range_min_i);
      wrapped = sum;
      // Reaching the upper limit already folds over to the lower one
      if (sum >= 33'(range_max_i)) begin
         wrapped = sum - span;
      end else if (sum < 33'(range_min_i)) begin
         wrapped = sum + span;
      end
      target_o = wrapped[31:0];
   end

   // Direction choice per rotary option
   always_comb begin
      diff = 33'(target_o) - 33'(actual_pos_i);
      if (diff < 0) begin
         diff = diff + span;
      end
      unique case (ppo_pkg::ppo_sel_t'(rot_sel_i))
         ppo_pkg::SEL_C0: dir_neg_o = (33'(target_o) < 33'(actual_pos_i));
         ppo_pkg::SEL_C1: dir_neg_o = 1'b1;
         ppo_pkg::SEL_C2: dir_neg_o = 1'b0;
         ppo_pkg::SEL_C3: dir_neg_o = !((diff <<< 1) < span);
      endcase
   end
endmodule : ppo_target_calc
`default_nettype wire

// ### core/ppo_option_logic.sv
// Profile position option logic: limit and option objects, setpoint
// handshake with automatic release, target and direction selection.
// Assumes a single-cycle object write/read port from the fieldbus stack and
// motion status from the trajectory generator on the same clock.
//
// How it works
// - Acceleration limit, 32 bits, preset 1388 hex, output to ramps.
// - Deceleration limit, 32 bits, preset 1388 hex, output to ramps.
// - Option word, 16 bits read/write, preset 0001 hex.
// - Fields: relative 1:0, handshake 5:4, rotary 7:6, interp 11:8, flag 15.
// - Relative base applies only when controlword bit 6 is set.
// - Code 00 adds to previous target, zero if none.
// - Code 01 adds to ramp generator output.
// - Code 10 adds to actual position; 11 reserved.
// - Auto release clears new setpoint, then clears setpoint acknowledge.
// - Code 00: device never clears new setpoint; master handshakes.
// - Code 01: release once current move reaches target.
// - Code 10: release at the earliest possible moment.
// - Rotary 00: linear, wrap at range limits, long moves allowed.
// - Rotary 01: negative direction only.
// - Rotary 10: positive direction only.
// - Rotary 11: shortest path, positive under half a turn.
// - Following error readable, signed 32 bits, preset zero.
// - Device may modify the controlword it receives.
`timescale 1ns/1ns
`default_nettype none
module ppo_option_logic (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // Object access port
   input wire logic OBJ_WR_I,
   input wire logic [15:0] OBJ_IDX_I,
   input wire logic [31:0] OBJ_WDATA_I,
   output logic [31:0] OBJ_RDATA_O,
   output logic OBJ_ERR_O,
   // Controlword from master
   input wire logic CW_WR_I,
   input wire logic [15:0] CW_WDATA_I,
   // Motion status
   input wire logic signed [31:0] RAMP_POS_I,
   input wire logic signed [31:0] ACTUAL_POS_I,
   input wire logic signed [31:0] FOLLOW_ERR_I,
   input wire logic signed [31:0] RANGE_MIN_I,
   input wire logic signed [31:0] RANGE_MAX_I,
   input wire logic TARGET_REACHED_I,
   input wire logic SETPOINT_READY_I,
   // Outputs
   output logic [15:0] CW_O,
   output logic SETPOINT_ACK_O,
   output logic [31:0] MAX_ACCEL_O,
   output logic [31:0] MAX_DECEL_O,
   output logic signed [31:0] TARGET_O,
   output logic DIR_NEG_O,
   output logic TARGET_LOAD_O
);
   logic [31:0] max_accel_reg;
   logic [31:0] max_decel_reg;
   logic [15:0] pos_opt_reg;
   logic signed [31:0] track_err_reg;
   logic [15:0] cw_reg;
   logic ack_reg;
   logic has_prev_reg;
   logic signed [31:0] prev_target_reg;
   logic signed [31:0] target_reg;
   logic dir_neg_reg;
   logic load_reg;
   logic [31:0] rdata_reg;
   logic err_reg;
   logic move_busy_reg;
   logic [1:0] rel_sel;
   logic [1:0] hsk_sel;
   logic [1:0] rot_sel;
   logic signed [31:0] calc_target;
   logic calc_dir;
   logic new_sp_rise;
   logic release_now;

   ////////////////////////////////////////////////////////////////////////////
   // Field extraction
   ////////////////////////////////////////////////////////////////////////////

   assign rel_sel = pos_opt_reg[ppo_pkg::REL_LSB +: 2];
   assign hsk_sel = pos_opt_reg[ppo_pkg::HSK_LSB +: 2];
   assign rot_sel = pos_opt_reg[ppo_pkg::ROT_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // Object registers
   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         max_accel_reg <= ppo_pkg::RST_MAX_ACCEL;
      end else if (OBJ_WR_I && OBJ_IDX_I == ppo_pkg::IDX_MAX_ACCEL) begin
         max_accel_reg <= OBJ_WDATA_I;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         max_decel_reg <= ppo_pkg::RST_MAX_DECEL;
      end else if (OBJ_WR_I && OBJ_IDX_I == ppo_pkg::IDX_MAX_DECEL) begin
         max_decel_reg <= OBJ_WDATA_I;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         pos_opt_reg <= ppo_pkg::RST_POS_OPT;
      end else if (OBJ_WR_I && OBJ_IDX_I == ppo_pkg::IDX_POS_OPT) begin
         pos_opt_reg <= OBJ_WDATA_I[15:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         track_err_reg <= ppo_pkg::RST_TRACK_ERR;
      end else begin
         track_err_reg <= FOLLOW_ERR_I;
      end
   end

   // Read mux and error on unknown index or read-only write
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rdata_reg <= '0;
         err_reg <= 1'b0;
      end else begin
         err_reg <= 1'b0;
         unique case (OBJ_IDX_I)
            ppo_pkg::IDX_MAX_ACCEL: rdata_reg <= max_accel_reg;
            ppo_pkg::IDX_MAX_DECEL: rdata_reg <= max_decel_reg;
            ppo_pkg::IDX_POS_OPT: rdata_reg <= {16'h0000, pos_opt_reg};
            ppo_pkg::IDX_TRACK_ERR: begin
               rdata_reg <= track_err_reg;
               err_reg <= OBJ_WR_I;
            end
            default: begin
               rdata_reg <= '0;
               err_reg <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Setpoint handshake
   ////////////////////////////////////////////////////////////////////////////

   assign new_sp_rise = CW_WR_I && CW_WDATA_I[ppo_pkg::CW_NEW_SETPOINT]
      && !cw_reg[ppo_pkg::CW_NEW_SETPOINT];

   always_comb begin
      release_now = 1'b0;
      unique case (ppo_pkg::ppo_sel_t'(hsk_sel))
         // Only a move that was actually started may count as arrived
         ppo_pkg::SEL_C1: release_now = ack_reg && move_busy_reg && TARGET_REACHED_I && !load_reg;
         ppo_pkg::SEL_C2: release_now = ack_reg && SETPOINT_READY_I;
         ppo_pkg::SEL_C0, ppo_pkg::SEL_C3: release_now = 1'b0;
      endcase
   end

   // controlword held, device clears new setpoint
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         cw_reg <= '0;
      end else if (CW_WR_I) begin
         cw_reg <= CW_WDATA_I;
      end else if (release_now) begin
         cw_reg[ppo_pkg::CW_NEW_SETPOINT] <= 1'b0;
      end
   end

   // acknowledge set on accept, cleared after release
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ack_reg <= 1'b0;
      end else if (new_sp_rise) begin
         ack_reg <= 1'b1;
      end else if (!cw_reg[ppo_pkg::CW_NEW_SETPOINT]) begin
         ack_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Target computation
   ////////////////////////////////////////////////////////////////////////////

   ppo_target_calc u_calc (
      .rel_sel_i(rel_sel),
      .rot_sel_i(rot_sel),
      .relative_i(CW_WDATA_I[ppo_pkg::CW_RELATIVE]),
      .has_prev_i(has_prev_reg),
      .setpoint_i($signed(OBJ_WDATA_I)),
      .prev_target_i(prev_target_reg),
      .ramp_pos_i(RAMP_POS_I),
      .actual_pos_i(ACTUAL_POS_I),
      .range_min_i(RANGE_MIN_I),
      .range_max_i(RANGE_MAX_I),
      .target_o(calc_target),
      .dir_neg_o(calc_dir)
   );

   // latch new target on setpoint accept
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         target_reg <= '0;
         prev_target_reg <= '0;
         has_prev_reg <= 1'b0;
         dir_neg_reg <= 1'b0;
         load_reg <= 1'b0;
      end else begin
         load_reg <= new_sp_rise;
         if (new_sp_rise) begin
            target_reg <= calc_target;
            prev_target_reg <= calc_target;
            has_prev_reg <= 1'b1;
            dir_neg_reg <= calc_dir;
         end
      end
   end

   // Motion in progress tracker
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         move_busy_reg <= 1'b0;
      end else if (load_reg) begin
         move_busy_reg <= 1'b1;
      end else if (TARGET_REACHED_I) begin
         move_busy_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////////////

   assign OBJ_RDATA_O = rdata_reg;
   assign OBJ_ERR_O = err_reg;
   assign CW_O = cw_reg;
   assign SETPOINT_ACK_O = ack_reg;
   assign MAX_ACCEL_O = max_accel_reg;
   assign MAX_DECEL_O = max_decel_reg;
   assign TARGET_O = target_reg;
   assign DIR_NEG_O = dir_neg_reg;
   assign TARGET_LOAD_O = load_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   ////////////////////////////////////////////////////////////////////////////

   property p_accel_write;
      @(posedge CLK_I) disable iff (!RST_N_I)
      OBJ_WR_I && OBJ_IDX_I == ppo_pkg::IDX_MAX_ACCEL |=> MAX_ACCEL_O == $past(OBJ_WDATA_I);
   endproperty
   a_accel_write: assert property (p_accel_write) else $error("accel limit not stored");

   property p_decel_write;
      @(posedge CLK_I) disable iff (!RST_N_I)
      OBJ_WR_I && OBJ_IDX_I == ppo_pkg::IDX_MAX_DECEL |=> MAX_DECEL_O == $past(OBJ_WDATA_I);
   endproperty
   a_decel_write: assert property (p_decel_write) else $error("decel limit not stored");

   property p_opt_readback;
      @(posedge CLK_I) disable iff (!RST_N_I)
      OBJ_WR_I && OBJ_IDX_I == ppo_pkg::IDX_POS_OPT ##1 !OBJ_WR_I && OBJ_IDX_I == ppo_pkg::IDX_POS_OPT
      |=> OBJ_RDATA_O[15:0] == $past(OBJ_WDATA_I[15:0], 2);
   endproperty
   a_opt_readback: assert property (p_opt_readback) else $error("option word readback wrong");

   property p_no_release_c0;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (hsk_sel == 2'b00 || hsk_sel == 2'b11) && !CW_WR_I && cw_reg[ppo_pkg::CW_NEW_SETPOINT]
      |=> cw_reg[ppo_pkg::CW_NEW_SETPOINT];
   endproperty
   a_no_release_c0: assert property (p_no_release_c0) else $error("device cleared setpoint");

   property p_release_ack;
      @(posedge CLK_I) disable iff (!RST_N_I)
      release_now && !CW_WR_I |=> !cw_reg[ppo_pkg::CW_NEW_SETPOINT] ##1 !SETPOINT_ACK_O;
   endproperty
   a_release_ack: assert property (p_release_ack) else $error("ack not cleared after release");

   property p_fast_release;
      @(posedge CLK_I) disable iff (!RST_N_I)
      hsk_sel == 2'b10 && ack_reg && SETPOINT_READY_I && !CW_WR_I
      |=> !cw_reg[ppo_pkg::CW_NEW_SETPOINT];
   endproperty
   a_fast_release: assert property (p_fast_release) else $error("early release missed");

   property p_track_err;
      @(posedge CLK_I) disable iff (!RST_N_I)
      1'b1 |=> track_err_reg == $past(FOLLOW_ERR_I);
   endproperty
   a_track_err: assert property (p_track_err) else $error("following error stale");

   property p_rot_dir;
      @(posedge CLK_I) disable iff (!RST_N_I)
      new_sp_rise && rot_sel == 2'b01 |=> DIR_NEG_O && TARGET_LOAD_O;
   endproperty
   a_rot_dir: assert property (p_rot_dir) else $error("negative-only direction broken");
endmodule : ppo_option_logic
`default_nettype wire

// ### bench/ppo_master_model.sv
// Fieldbus master model: object writes and reads, controlword writes.
// Assumes the device samples every request on the rising CLK_I edge.
`timescale 1ns/1ns
`default_nettype none
module ppo_master_model (
   input wire logic CLK_I,
   input wire logic [31:0] rdata_i,
   input wire logic err_i,
   output logic obj_wr_o,
   output logic [15:0] obj_idx_o,
   output logic [31:0] obj_wdata_o,
   output logic cw_wr_o,
   output logic [15:0] cw_wdata_o
);
   // Idle bus from time zero
   initial begin
      obj_wr_o = 1'b0;
      obj_idx_o = 16'h0000;
      obj_wdata_o = 32'h0000_0000;
      cw_wr_o = 1'b0;
      cw_wdata_o = 16'h0000;
   end
   // Single-cycle write; data inverted once released, error taken after answer
   task obj_write(input logic [15:0] idx, input logic [31:0] d, output logic err);
      @(posedge CLK_I);
      obj_wr_o <= 1'b1;
      obj_idx_o <= idx;
      obj_wdata_o <= d;
      @(posedge CLK_I);
      obj_wr_o <= 1'b0;
      obj_wdata_o <= ~d;
      #1 err = err_i;
   endtask : obj_write
   // Read: index held, registered data taken one cycle later
   task obj_read(input logic [15:0] idx, output logic [31:0] rd);
      @(posedge CLK_I);
      obj_idx_o <= idx;
      @(posedge CLK_I);
      #1 rd = rdata_i;
   endtask : obj_read
   task cw_write(input logic [15:0] cw, input logic [31:0] sp);
      @(posedge CLK_I);
      cw_wr_o <= 1'b1;
      cw_wdata_o <= cw;
      obj_wdata_o <= sp;
      @(posedge CLK_I);
      cw_wr_o <= 1'b0;
      obj_wdata_o <= ~sp;
   endtask : cw_write
endmodule : ppo_master_model
`default_nettype wire

// ### bench/tb.sv
// Testbench for the profile position option block.
// Assumes the master model in ppo_master_model and one 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk, rst_n, reached, ready, e, ld, dn, ak;
   logic [31:0] ramp, act, ferr, rmin, rmax, rd, rdata, accel, decel, tgt;
   logic obj_wr, cw_wr, err;
   logic [15:0] obj_idx, cw_wdata, cw_o;
   logic [31:0] obj_wdata;
   int n_fail, samples_checked, cyc;
   ppo_master_model m (.CLK_I(clk), .rdata_i(rdata), .err_i(err), .obj_wr_o(obj_wr),
      .obj_idx_o(obj_idx), .obj_wdata_o(obj_wdata), .cw_wr_o(cw_wr), .cw_wdata_o(cw_wdata));
   ppo_option_logic dut (.CLK_I(clk), .RST_N_I(rst_n), .OBJ_WR_I(obj_wr),
      .OBJ_IDX_I(obj_idx), .OBJ_WDATA_I(obj_wdata), .OBJ_RDATA_O(rdata), .OBJ_ERR_O(err),
      .CW_WR_I(cw_wr), .CW_WDATA_I(cw_wdata), .RAMP_POS_I(ramp), .ACTUAL_POS_I(act),
      .FOLLOW_ERR_I(ferr), .RANGE_MIN_I(rmin), .RANGE_MAX_I(rmax),
      .TARGET_REACHED_I(reached), .SETPOINT_READY_I(ready), .CW_O(cw_o),
      .SETPOINT_ACK_O(ak), .MAX_ACCEL_O(accel), .MAX_DECEL_O(decel), .TARGET_O(tgt),
      .DIR_NEG_O(dn), .TARGET_LOAD_O(ld));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang limit
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [15:0] idx, input logic [31:0] d, input logic xe);
      m.obj_write(idx, d, e);
      chk(e, xe);
   endtask : wr
   task rdc(input logic [15:0] idx, input logic [31:0] xv);
      m.obj_read(idx, rd);
      chk(rd, xv);
   endtask : rdc
   task opt(input logic [1:0] rel, input logic [1:0] hsk, input logic [1:0] rot);
      wr(ppo_pkg::IDX_POS_OPT, {24'h000000, rot, hsk, 2'h0, rel}, 1'b0);
   endtask : opt
   // Mode 0 master clears, 1 device clears at once, 2 device clears on arrival
   task move(input logic [15:0] cw, input logic [31:0] sp, input logic [31:0] xt,
      input logic xd, input int mode);
      int k;
      m.cw_write(cw | 16'h0020, sp);
      for (k = 0; k < 4; k++) begin
         #1 if (ld === 1'b1) break;
         @(posedge clk);
      end
      chk(ld, 1'b1);
      chk(tgt, xt);
      chk(dn, xd);
      chk(ak, 1'b1);
      if (mode != 1) begin
         repeat (4) @(posedge clk);
         #1 chk(cw_o[5], 1'b1);
      end
      if (mode == 0) m.cw_write(cw, sp);
      if (mode == 2) begin
         @(posedge clk);
         reached <= 1'b1;
      end
      repeat (4) @(posedge clk);
      #1 chk(cw_o[5], 1'b0);
      chk(ak, 1'b0);
   endtask : move
   task wrap_up;
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      n_fail = 0;
      samples_checked = 0;
      cyc = 0;
      rst_n = 1'b0;
      reached = 1'b1;
      ready = 1'b1;
      ramp = 32'h0000_0064;
      act = 32'h0000_00C8;
      ferr = 32'h0000_0000;
      rmin = 32'hFFFE_7960;
      rmax = 32'h0001_86A0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk(accel, 32'h0000_1388);
      chk(decel, 32'h0000_1388);
      rdc(ppo_pkg::IDX_MAX_ACCEL, 32'h0000_1388);
      rdc(ppo_pkg::IDX_MAX_DECEL, 32'h0000_1388);
      rdc(ppo_pkg::IDX_POS_OPT, 32'h0000_0001);
      rdc(ppo_pkg::IDX_TRACK_ERR, 32'h0000_0000);
      @(posedge clk);
      ferr <= 32'hFFFF_FFFB;
      wr(ppo_pkg::IDX_TRACK_ERR, 32'h0000_0007, 1'b1);
      rdc(ppo_pkg::IDX_TRACK_ERR, 32'hFFFF_FFFB);
      wr(16'h1234, 32'h0000_0007, 1'b1);
      wr(ppo_pkg::IDX_MAX_ACCEL, 32'hDEAD_BEEF, 1'b0);
      wr(ppo_pkg::IDX_MAX_DECEL, 32'h0000_FFFF, 1'b0);
      chk(accel, 32'hDEAD_BEEF);
      chk(decel, 32'h0000_FFFF);
      rdc(ppo_pkg::IDX_MAX_ACCEL, 32'hDEAD_BEEF);
      wr(ppo_pkg::IDX_POS_OPT, 32'hFFFF_8F0C, 1'b0);
      rdc(ppo_pkg::IDX_POS_OPT, 32'h0000_8F0C);
      move(16'h0040, 32'h0000_0032, 32'h0000_0032, 1'b1, 0);
      move(16'h0000, 32'h0000_012C, 32'h0000_012C, 1'b0, 0);
      move(16'h0040, 32'h0000_000A, 32'h0000_0136, 1'b0, 0);
      opt(2'h1, 2'h0, 2'h0);
      move(16'h0040, 32'h0000_000A, 32'h0000_006E, 1'b1, 0);
      opt(2'h2, 2'h0, 2'h0);
      move(16'h0040, 32'h0000_000A, 32'h0000_00D2, 1'b0, 0);
      opt(2'h3, 2'h0, 2'h0);
      move(16'h0040, 32'h0000_000A, 32'h0000_00DC, 1'b0, 0);
      opt(2'h0, 2'h2, 2'h0);
      move(16'h0000, 32'h0000_01F4, 32'h0000_01F4, 1'b0, 1);
      opt(2'h0, 2'h3, 2'h0);
      move(16'h0000, 32'h0000_0064, 32'h0000_0064, 1'b1, 0);
      opt(2'h0, 2'h1, 2'h0);
      @(posedge clk);
      reached <= 1'b0;
      move(16'h0000, 32'h0000_0096, 32'h0000_0096, 1'b1, 2);
      @(posedge clk);
      rmin <= 32'h0000_0000;
      rmax <= 32'h0000_0168;
      act <= 32'h0000_0064;
      opt(2'h0, 2'h0, 2'h1);
      move(16'h0000, 32'h0000_00C8, 32'h0000_00C8, 1'b1, 0);
      opt(2'h0, 2'h0, 2'h2);
      move(16'h0000, 32'h0000_0032, 32'h0000_0032, 1'b0, 0);
      opt(2'h0, 2'h0, 2'h3);
      move(16'h0000, 32'h0000_00BE, 32'h0000_00BE, 1'b0, 0);
      move(16'h0000, 32'h0000_000A, 32'h0000_000A, 1'b1, 0);
      opt(2'h0, 2'h0, 2'h0);
      move(16'h0000, 32'h0000_0032, 32'h0000_0032, 1'b1, 0);
      move(16'h0040, 32'h0000_0136, 32'h0000_0000, 1'b1, 0);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
